// File: mip_mmd_portal.sv
`timescale 1ns/1ps
// Operation
// - Setup and data portals reach 32 devices of 65536 16-bit registers.
// - Only LED style, WakeTx timer and EEE advert registers are implemented by map.
// - Setup with data function makes data portal hit selected register.
// - Data portal write in data function stores into selected register.
// - Data portal read in data function returns selected register.
// - LED bit 4 single-LED mode, reset 0; 15:5 zero, 3:0 0001b.
// - WakeTx timer device 3 register 0Eh, 16-bit RW, reset 0025h.
// - Advert bit 2 gigabit EEE, reset 1; 15:3 and 0 read zero.
// - Advert bit 1 100 Mbps EEE, reset 1, host writable.
module mip_mmd_portal (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic portalSel,
  input wire logic portalWr,
  input wire logic portalRd,
  input wire logic [15:0] portalWdata,
  output logic [15:0] portalRdata,
  output logic portalRvalid,
  output logic ledSingleMode,
  output logic [15:0] wakeTimer,
  output logic eee1000Adv,
  output logic eee100Adv
);
  // ==========================================
  // State
  typedef struct packed {
    mip_pkg::mip_func_e func;
    logic [4:0] dev;
    logic [15:0] regAddr;
    logic [15:0] rdata;
    logic rvalid;
  } mip_portal_s;

  mip_portal_s cur_ff;
  mip_portal_s nxt_cur;
  logic dataFunc;
  logic storeWr;
  logic [15:0] storeRdata;

  // ==========================================
  // Register store
  // Address wider than the map; unmapped entries read zero, drop writes
  mip_mmd_store u_store (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .wrEn(storeWr),
    .devAddr(cur_ff.dev),
    .regAddr(cur_ff.regAddr),
    .wrData(portalWdata),
    .rdData(storeRdata),
    .ledSingleMode(ledSingleMode),
    .wakeTimer(wakeTimer),
    .eee1000Adv(eee1000Adv),
    .eee100Adv(eee100Adv)
  );

  // ==========================================
  // Portal logic
  always_comb begin
    dataFunc = (cur_ff.func != mip_pkg::MIP_FUNC_ADDR);
    // Simultaneous read and write: write wins, read still answered
    storeWr = portalWr && (portalSel == mip_pkg::PORTAL_DATA)
              && dataFunc;
    nxt_cur = cur_ff;
    nxt_cur.rvalid = 1'h0;
    if (portalRd) begin
      nxt_cur.rvalid = 1'h1;
      if (portalSel == mip_pkg::PORTAL_SETUP) begin
        nxt_cur.rdata = {cur_ff.func, 9'h000, cur_ff.dev};
      end else if (dataFunc) begin
        nxt_cur.rdata = storeRdata;
        if (cur_ff.func == mip_pkg::MIP_FUNC_INC_RW) begin
          nxt_cur.regAddr = cur_ff.regAddr + 16'h0001;
        end
      end else begin
        nxt_cur.rdata = cur_ff.regAddr;
      end
    end
    if (portalWr) begin
      if (portalSel == mip_pkg::PORTAL_SETUP) begin
        nxt_cur.func = mip_pkg::mip_func_e'(
          portalWdata[mip_pkg::SETUP_FUNC_LSB +: 2]);
        nxt_cur.dev = portalWdata[mip_pkg::SETUP_DEV_LSB +: 5];
      end else if (!dataFunc) begin
        nxt_cur.regAddr = portalWdata;
      end else if (cur_ff.func != mip_pkg::MIP_FUNC_DATA) begin
        // Post-increment lets a host stream consecutive registers
        nxt_cur.regAddr = cur_ff.regAddr + 16'h0001;
      end
    end
    if (!rst_b) begin
      nxt_cur.func = mip_pkg::MIP_FUNC_ADDR;
      nxt_cur.dev = mip_pkg::SETUP_DEV_RST;
      nxt_cur.regAddr = mip_pkg::REG_ADDR_RST;
      nxt_cur.rdata = mip_pkg::RDATA_RST;
      nxt_cur.rvalid = 1'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    cur_ff <= nxt_cur;
  end

  assign portalRdata = cur_ff.rdata;
  assign portalRvalid = cur_ff.rvalid;
endmodule

// File: mip_pkg.sv
// ==========================================
// Portal constants
package mip_pkg;
  localparam int DATA_W = 16;
  localparam int DEV_W = 5;
  localparam int REG_W = 16;
  localparam int MMD_DEV_COUNT = 32;
  localparam int MMD_REG_COUNT = 65536;
  // ==========================================
  // Portal selection
  localparam logic PORTAL_SETUP = 1'h0;
  localparam logic PORTAL_DATA = 1'h1;
  // ==========================================
  // Setup portal layout
  localparam int SETUP_DEV_LSB = 0;
  localparam int SETUP_FUNC_LSB = 14;
  localparam logic [1:0] SETUP_FUNC_RST = 2'h0;
  localparam logic [4:0] SETUP_DEV_RST = 5'h00;
  typedef enum logic [1:0] {
    MIP_FUNC_ADDR,
    MIP_FUNC_DATA,
    MIP_FUNC_INC_RW,
    MIP_FUNC_INC_WR
  } mip_func_e;
  // ==========================================
  // Implemented MMD registers
  localparam logic [4:0] DEV_LED = 5'h02;
  localparam logic [4:0] DEV_PMA = 5'h03;
  localparam logic [4:0] DEV_AN = 5'h07;
  localparam logic [15:0] REG_LED_STYLE = 16'h0000;
  localparam logic [15:0] REG_WAKE_TIMER = 16'h000E;
  localparam logic [15:0] REG_EEE_ADVERT = 16'h003C;
  localparam int LED_MODE_BIT = 4;
  localparam logic [3:0] LED_FIXED_LOW = 4'h1;
  localparam logic LED_MODE_RST = 1'h0;
  localparam logic [15:0] WAKE_TIMER_RST = 16'h0025;
  localparam int EEE_1000_BIT = 2;
  localparam int EEE_100_BIT = 1;
  localparam logic EEE_1000_RST = 1'h1;
  localparam logic EEE_100_RST = 1'h1;
  localparam logic [15:0] REG_ADDR_RST = 16'h0000;
  localparam logic [15:0] RDATA_RST = 16'h0000;
endpackage

// File: mip_mmd_store.sv
`timescale 1ns/1ps
// ==========================================
// MMD register store
module mip_mmd_store (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic wrEn,
  input wire logic [4:0] devAddr,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] wrData,
  output logic [15:0] rdData,
  output logic ledSingleMode,
  output logic [15:0] wakeTimer,
  output logic eee1000Adv,
  output logic eee100Adv
);
  typedef struct packed {
    logic ledMode;
    logic [15:0] wake;
    logic adv1000;
    logic adv100;
  } mip_store_s;

  mip_store_s cur_ff;
  mip_store_s nxt_cur;

  function automatic logic hit(input logic [4:0] d, input logic [15:0] r,
                               input logic [4:0] dd, input logic [15:0] rr);
    hit = (d == dd) && (r == rr);
  endfunction

  logic hitLed;
  logic hitWake;
  logic hitAdv;

  always_comb begin
    // Sparse decode; every other address reads zero
    hitLed = hit(devAddr, regAddr, mip_pkg::DEV_LED, mip_pkg::REG_LED_STYLE);
    hitWake = hit(devAddr, regAddr, mip_pkg::DEV_PMA,
                  mip_pkg::REG_WAKE_TIMER);
    hitAdv = hit(devAddr, regAddr, mip_pkg::DEV_AN, mip_pkg::REG_EEE_ADVERT);
    nxt_cur = cur_ff;
    if (wrEn && hitLed) begin
      nxt_cur.ledMode = wrData[mip_pkg::LED_MODE_BIT];
    end
    if (wrEn && hitWake) begin
      // Reserved codes are stored as written; no filtering
      nxt_cur.wake = wrData;
    end
    if (wrEn && hitAdv) begin
      nxt_cur.adv1000 = wrData[mip_pkg::EEE_1000_BIT];
      nxt_cur.adv100 = wrData[mip_pkg::EEE_100_BIT];
    end
    if (!rst_b) begin
      nxt_cur.ledMode = mip_pkg::LED_MODE_RST;
      nxt_cur.wake = mip_pkg::WAKE_TIMER_RST;
      nxt_cur.adv1000 = mip_pkg::EEE_1000_RST;
      nxt_cur.adv100 = mip_pkg::EEE_100_RST;
    end
  end

  always_comb begin
    rdData = 16'h0000;
    if (hitLed) begin
      rdData = {11'h000, cur_ff.ledMode, mip_pkg::LED_FIXED_LOW};
    end else if (hitWake) begin
      rdData = cur_ff.wake;
    end else if (hitAdv) begin
      rdData = {13'h0000, cur_ff.adv1000, cur_ff.adv100, 1'h0};
    end
  end

  always_ff @(posedge clk_sys) begin
    cur_ff <= nxt_cur;
  end

  assign ledSingleMode = cur_ff.ledMode;
  assign wakeTimer = cur_ff.wake;
  assign eee1000Adv = cur_ff.adv1000;
  assign eee100Adv = cur_ff.adv100;
endmodule

// File: mip_mmd_portal_props.sv
`timescale 1ns/1ps
// ==========================================
// Portal checker
module mip_portal_chk (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic portalSel,
  input wire logic portalWr,
  input wire logic portalRd,
  input wire logic [15:0] portalWdata,
  input wire logic [15:0] portalRdata,
  input wire logic portalRvalid,
  input wire logic ledSingleMode,
  input wire logic [15:0] wakeTimer,
  input wire logic eee1000Adv,
  input wire logic eee100Adv
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_rd_answer: assert property (
    portalRd |=> portalRvalid)
    else $error("read without answer");
  a_rvalid_cause: assert property (
    portalRvalid |-> $past(portalRd))
    else $error("answer without read");
  a_rdata_hold: assert property (
    !portalRvalid && $past(rst_b) |-> $stable(portalRdata))
    else $error("read data moved");
  a_wake_cause: assert property (
    $changed(wakeTimer) && $past(rst_b)
    |-> $past(portalWr && portalSel) && wakeTimer == $past(portalWdata))
    else $error("timer changed unasked");
  a_led_cause: assert property (
    $changed(ledSingleMode) && $past(rst_b)
    |-> $past(portalWr && portalSel)
    && ledSingleMode == $past(portalWdata[4]))
    else $error("led mode changed unasked");
  a_adv_cause: assert property (
    $changed({eee1000Adv, eee100Adv}) && $past(rst_b)
    |-> $past(portalWr && portalSel)
    && {eee1000Adv, eee100Adv} == $past(portalWdata[2:1]))
    else $error("advert changed unasked");
  a_reset_state: assert property (
    disable iff (1'b0) !rst_b |=>
    wakeTimer == 16'h0025 && eee1000Adv && eee100Adv && !ledSingleMode
    && !portalRvalid) else $error("bad reset state");
  a_no_spur_valid: assert property (
    !portalRd |=> !portalRvalid)
    else $error("answer stretched");
  c_read: cover property (portalRvalid);
  c_led: cover property ($rose(ledSingleMode));
  c_wake: cover property ($changed(wakeTimer));
endmodule
bind mip_mmd_portal mip_portal_chk mip_portal_chk_i (.clk_sys(clk_sys),
  .rst_b(rst_b), .portalSel(portalSel), .portalWr(portalWr),
  .portalRd(portalRd), .portalWdata(portalWdata), .portalRdata(portalRdata),
  .portalRvalid(portalRvalid), .ledSingleMode(ledSingleMode),
  .wakeTimer(wakeTimer), .eee1000Adv(eee1000Adv), .eee100Adv(eee100Adv));

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_sys, rst_b, portalSel, portalWr, portalRd, portalRvalid;
  logic ledSingleMode, eee1000Adv, eee100Adv;
  logic [15:0] portalWdata, portalRdata, wakeTimer;
  int err_count = 0;
  int n_compared = 0;
  mip_mmd_portal mip_mmd_portal_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .portalSel(portalSel), .portalWr(portalWr), .portalRd(portalRd),
    .portalWdata(portalWdata), .portalRdata(portalRdata),
    .portalRvalid(portalRvalid), .ledSingleMode(ledSingleMode),
    .wakeTimer(wakeTimer), .eee1000Adv(eee1000Adv), .eee100Adv(eee100Adv));
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;
  // ==========================================
  // Access tasks
  // One assignment per step; strobes drop only via the next call
  task automatic op(input logic w, r, s, input logic [15:0] d);
    portalWr = w;
    portalRd = r;
    portalSel = s;
    portalWdata = d;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pick(input logic [4:0] dv, input logic [15:0] ra);
    op(1'b1, 1'b0, 1'b0, {11'h000, dv});
    op(1'b1, 1'b0, 1'b1, ra);
    op(1'b1, 1'b0, 1'b0, {2'h1, 9'h000, dv});
  endtask
  task automatic rdm(input logic [4:0] dv, input logic [15:0] ra, exp);
    pick(dv, ra);
    op(1'b0, 1'b1, 1'b1, 16'h0000);
    chk({15'h0000, portalRvalid}, 16'h0001);
    chk(portalRdata, exp);
  endtask
  task automatic wrm(input logic [4:0] dv, input logic [15:0] ra, d);
    pick(dv, ra);
    op(1'b1, 1'b0, 1'b1, d);
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================
  // Tests
  initial begin
    #20000;
    err_count++;
    wrap_up;
  end
  initial begin
    rst_b = 1'b0;
    op(1'b0, 1'b0, 1'b0, 16'h0000);
    repeat (19) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    chk(wakeTimer, 16'h0025);
    chk({14'h0000, eee1000Adv, eee100Adv}, 16'h0003);
    rdm(5'h02, 16'h0000, 16'h0001);
    rdm(5'h03, 16'h000E, 16'h0025);
    rdm(5'h07, 16'h003C, 16'h0006);
    $display("test reset values done");
    wrm(5'h02, 16'h0000, 16'hFFFF);
    chk({15'h0000, ledSingleMode}, 16'h0001);
    rdm(5'h02, 16'h0000, 16'h0011);
    wrm(5'h07, 16'h003C, 16'hFFFB);
    rdm(5'h07, 16'h003C, 16'h0002);
    wrm(5'h03, 16'h000E, 16'h0021);
    chk(wakeTimer, 16'h0021);
    rdm(5'h03, 16'h000E, 16'h0021);
    $display("test data writes done");
    wrm(5'h04, 16'h0000, 16'h1234);
    rdm(5'h04, 16'h0000, 16'h0000);
    op(1'b0, 1'b1, 1'b0, 16'h0000);
    chk(portalRdata, 16'h4004);
    op(1'b0, 1'b0, 1'b0, 16'h0000);
    chk({15'h0000, portalRvalid}, 16'h0000);
    $display("test unmapped and setup done");
    // Post-increment function: write 0Dh then read lands on 0Eh
    op(1'b1, 1'b0, 1'b0, 16'h0003);
    op(1'b1, 1'b0, 1'b1, 16'h000D);
    op(1'b1, 1'b0, 1'b0, 16'h8003);
    op(1'b1, 1'b0, 1'b1, 16'h0025);
    op(1'b0, 1'b1, 1'b1, 16'h0000);
    chk(portalRdata, 16'h0021);
    op(1'b0, 1'b1, 1'b1, 16'h0000);
    chk(portalRdata, 16'h0000);
    op(1'b0, 1'b0, 1'b0, 16'h0000);
    chk(wakeTimer, 16'h0021);
    $display("test increment done");
    wrap_up;
  end
endmodule
